// ### hdl/pcs_sequencer.sv
// Purpose: Power configuration sequencer with APB register access
// Assumes: Single clock ref_clk at 200 MHz, synchronous active-high reset
// Notes:   Zero-wait APB is not possible with registered pready; one wait state

// Function
// RULE1 - No single register selects a configuration; it follows from several domain and clock registers.
// RULE2 - Software enables at least one usable wake source before entering a reduced configuration.
// RULE3 - Software reads back and clears the idle bits of each peripheral and port before using it.
// RULE4 - Regulator and bandgap power-down bits together enter RTC-only mode, left on RTC interrupt or wake pin.
// RULE5 - Light idle keeps all power, the RTC clock and the PLL running and stops CPU and peripheral clocks.
// RULE6 - Deep idle keeps all power and only the RTC clock, with the clock generator bypassed and PLL down.
// RULE7 - Either idle is left on wake pin, RTC interrupt, either external line, a qualifying peripheral, or reset.
// RULE8 - A peripheral interrupt wakes only if flagged in the two CPU flag registers and enabled.
// RULE9 - Active has every power domain on and every clock domain enabled; the code clocks only domains whose idle or PLL power-down bits are clear.
// RULE10 - The idle instruction copies the idle configuration into the idle status and gates CPU clocks from it.
// RULE11 - Waking from RTC-only mode reboots the RTC logic.
module pcs_sequencer (
  input  wire logic                           ref_clk,
  input  wire logic                           reset,
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [7:0]                     paddr,
  input  wire logic [31:0]                    pwdata,
  output logic                                pready,
  output logic [31:0]                         prdata,
  output logic                                pslverr,
  input  wire logic                           idleInstr,
  input  wire logic                           wakeRequestPin,
  input  wire logic                           rtcIrq,
  input  wire logic                           externalIrqA,
  input  wire logic                           externalIrqB,
  input  wire logic [2*pcs_pkg::FLAG_W-1:0]   periphIrq,
  output logic [pcs_pkg::IDLE_W-1:0]          cpuDomClkEn,
  output logic [pcs_pkg::PERIPH_W-1:0]        periphClkEn,
  output logic                                pllRun,
  output logic                                clkGenBypass,
  output logic                                rtcClkEn,
  output logic                                coreDomPowerOn,
  output logic                                rtcReboot,
  output logic                                irq
);

  pcs_pkg::pcs_idle_cfg_s          idleCfg_q;
  pcs_pkg::pcs_idle_cfg_s          idleStat_q;
  logic [pcs_pkg::PERIPH_W-1:0]    periphIdle_q;
  logic [1:0]                      clkGen_q;
  logic [2:0]                      rtcPwr_q;
  logic [2*pcs_pkg::FLAG_W-1:0]    irqEn_q;
  logic [pcs_pkg::EVT_W-1:0]       evtMask_q;
  pcs_pkg::pcs_cfg_e               cfg_q;
  logic                            pready_q;
  logic [31:0]                     prdata_q;
  logic                            pslverr_q;
  logic [pcs_pkg::IDLE_W-1:0]      cpuDomClkEn_q;
  logic [pcs_pkg::PERIPH_W-1:0]    periphClkEn_q;
  logic                            pllRun_q;
  logic                            clkGenBypass_q;
  logic                            coreDomPowerOn_q;
  logic                            rtcReboot_q;
  logic                            rtcClkEn_q;
  logic                            irq_q;

  logic                            wrCommit;
  logic                            rdCommit;
  logic                            mapped;
  logic [31:0]                     rdMux;
  logic [2*pcs_pkg::FLAG_W-1:0]    flagClr;
  logic [2*pcs_pkg::FLAG_W-1:0]    irqFlags;
  logic [pcs_pkg::EVT_W-1:0]       evtSet;
  logic [pcs_pkg::EVT_W-1:0]       evtClr;
  logic [pcs_pkg::EVT_W-1:0]       evtStat;
  logic                            idleWake;
  logic                            rtcOnlyWake;
  logic                            enterIdle;
  logic                            enterRtcOnly;
  logic                            deepReady;
  pcs_pkg::pcs_wake_s              wakeSrcs;

  // Transfer commits at the edge where pready is seen high
  assign wrCommit = psel & penable & pready_q & pwrite;
  assign rdCommit = psel & penable & pready_q & ~pwrite;

  // Address decode and read data selection
  always_comb begin
    mapped = 1'b1;
    rdMux  = 32'h0000_0000;
    unique case (paddr)
      pcs_pkg::OFF_IDLE_CFG:   rdMux[pcs_pkg::IDLE_W-1:0]   = idleCfg_q; // RULE3
      pcs_pkg::OFF_IDLE_STAT:  rdMux[pcs_pkg::IDLE_W-1:0]   = idleStat_q;
      pcs_pkg::OFF_PERIPH_IDL: rdMux[pcs_pkg::PERIPH_W-1:0] = periphIdle_q;
      pcs_pkg::OFF_CLKGEN:     rdMux[1:0]                   = clkGen_q;
      pcs_pkg::OFF_RTC_PWR:    rdMux[2:0]                   = rtcPwr_q;
      pcs_pkg::OFF_FLAGS_LOW:  rdMux[pcs_pkg::FLAG_W-1:0]   = irqFlags[pcs_pkg::FLAG_W-1:0];
      pcs_pkg::OFF_FLAGS_HIGH: rdMux[pcs_pkg::FLAG_W-1:0]   = irqFlags[2*pcs_pkg::FLAG_W-1:pcs_pkg::FLAG_W];
      pcs_pkg::OFF_EN_LOW:     rdMux[pcs_pkg::FLAG_W-1:0]   = irqEn_q[pcs_pkg::FLAG_W-1:0];
      pcs_pkg::OFF_EN_HIGH:    rdMux[pcs_pkg::FLAG_W-1:0]   = irqEn_q[2*pcs_pkg::FLAG_W-1:pcs_pkg::FLAG_W];
      pcs_pkg::OFF_CONFIG:     rdMux[2:0]                   = cfg_q;
      pcs_pkg::OFF_EVT_STAT:   rdMux[pcs_pkg::EVT_W-1:0]    = evtStat;
      pcs_pkg::OFF_EVT_MASK:   rdMux[pcs_pkg::EVT_W-1:0]    = evtMask_q;
      default:                 mapped                       = 1'b0;
    endcase
  end

  // APB answer, one wait state in every access
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel & penable & ~pready_q) begin
      pready_q  <= 1'b1;
      prdata_q  <= pwrite ? 32'h0000_0000 : rdMux;
      pslverr_q <= ~mapped;
    end else begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
  end

  // Separate domain and clock control registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      idleCfg_q    <= pcs_pkg::IDLE_CFG_RST;
      periphIdle_q <= pcs_pkg::PERIPH_IDL_RST;
      clkGen_q     <= pcs_pkg::CLKGEN_RST;
      irqEn_q      <= '0;
      evtMask_q    <= '0;
    end else if (wrCommit) begin
      unique case (paddr)
        pcs_pkg::OFF_IDLE_CFG:   idleCfg_q    <= pwdata[pcs_pkg::IDLE_W-1:0]; // RULE1
        pcs_pkg::OFF_PERIPH_IDL: periphIdle_q <= pwdata[pcs_pkg::PERIPH_W-1:0]; // RULE1
        pcs_pkg::OFF_CLKGEN:     clkGen_q     <= pwdata[1:0]; // RULE1
        pcs_pkg::OFF_EN_LOW:     irqEn_q[pcs_pkg::FLAG_W-1:0] <= pwdata[pcs_pkg::FLAG_W-1:0];
        pcs_pkg::OFF_EN_HIGH:    irqEn_q[2*pcs_pkg::FLAG_W-1:pcs_pkg::FLAG_W] <= pwdata[pcs_pkg::FLAG_W-1:0];
        pcs_pkg::OFF_EVT_MASK:   evtMask_q    <= pwdata[pcs_pkg::EVT_W-1:0];
        default: ;
      endcase
    end
  end

  // RTC power control, power-down bits drop when the RTC logic reboots
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rtcPwr_q <= pcs_pkg::RTC_PWR_RST;
    end else if (cfg_q == pcs_pkg::CFG_REBOOT) begin
      rtcPwr_q <= pcs_pkg::RTC_PWR_RST; // RULE11
    end else if (wrCommit && paddr == pcs_pkg::OFF_RTC_PWR) begin
      rtcPwr_q <= pwdata[2:0];
    end
  end

  // CPU interrupt flags, write one to clear
  always_comb begin
    flagClr = '0;
    if (wrCommit && paddr == pcs_pkg::OFF_FLAGS_LOW) begin
      flagClr[pcs_pkg::FLAG_W-1:0] = pwdata[pcs_pkg::FLAG_W-1:0];
    end
    if (wrCommit && paddr == pcs_pkg::OFF_FLAGS_HIGH) begin
      flagClr[2*pcs_pkg::FLAG_W-1:pcs_pkg::FLAG_W] = pwdata[pcs_pkg::FLAG_W-1:0];
    end
  end

  pcs_flag_bank #(
    .W (2*pcs_pkg::FLAG_W)
  ) u_irqFlags (
    .ref_clk (ref_clk),
    .reset   (reset),
    .setVec  (periphIrq),
    .clrVec  (flagClr),
    .flags   (irqFlags)
  );

  // Wake source qualification
  assign wakeSrcs.pin  = wakeRequestPin & rtcPwr_q[pcs_pkg::RTC_WAKE_DIR_BIT];
  assign wakeSrcs.rtc  = rtcIrq;
  assign wakeSrcs.extA = externalIrqA;
  assign wakeSrcs.extB = externalIrqB;

  pcs_wake_detect u_wake (
    .ref_clk     (ref_clk),
    .reset       (reset),
    .srcs        (wakeSrcs),
    .flags       (irqFlags),
    .enables     (irqEn_q),
    .idleWake    (idleWake),
    .rtcOnlyWake (rtcOnlyWake)
  );

  // Entry conditions built from several registers
  assign enterRtcOnly = rtcPwr_q[pcs_pkg::RTC_REG_PD_BIT] & rtcPwr_q[pcs_pkg::RTC_BANDGAP_POWER_DOWN_BIT_BIT]; // RULE4
  assign deepReady    = clkGen_q[pcs_pkg::CLKGEN_BYPASS_BIT] & clkGen_q[pcs_pkg::CLKGEN_PLLPD_BIT]; // RULE6
  assign enterIdle    = idleInstr & (cfg_q == pcs_pkg::CFG_ACTIVE) & ~enterRtcOnly;

  // Configuration state
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg_q <= pcs_pkg::CFG_ACTIVE; // RULE7
    end else begin
      unique case (cfg_q)
        pcs_pkg::CFG_ACTIVE: begin
          if (enterRtcOnly) begin
            cfg_q <= pcs_pkg::CFG_RTC_ONLY; // RULE4
          end else if (enterIdle && idleCfg_q.cpu) begin
            cfg_q <= deepReady ? pcs_pkg::CFG_DEEP_IDLE : pcs_pkg::CFG_LIGHT_IDLE; // RULE5 RULE6
          end
        end
        pcs_pkg::CFG_LIGHT_IDLE,
        pcs_pkg::CFG_DEEP_IDLE: begin
          if (idleWake) begin
            cfg_q <= pcs_pkg::CFG_ACTIVE; // RULE7
          end
        end
        pcs_pkg::CFG_RTC_ONLY: begin
          if (rtcOnlyWake) begin
            cfg_q <= pcs_pkg::CFG_REBOOT; // RULE11
          end
        end
        pcs_pkg::CFG_REBOOT: cfg_q <= pcs_pkg::CFG_ACTIVE;
        default:             cfg_q <= pcs_pkg::CFG_ACTIVE;
      endcase
    end
  end

  // Idle status captured by the idle instruction, its cpu bit released on wake
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      idleStat_q <= pcs_pkg::IDLE_CFG_RST;
    end else if (enterIdle) begin
      idleStat_q <= idleCfg_q; // RULE10
    end else if ((cfg_q == pcs_pkg::CFG_LIGHT_IDLE || cfg_q == pcs_pkg::CFG_DEEP_IDLE) && idleWake) begin
      idleStat_q.cpu <= 1'b0; // RULE7
    end
  end

  // Clock and power domain enables
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cpuDomClkEn_q    <= '1;
      periphClkEn_q    <= '1;
      pllRun_q         <= 1'b1;
      clkGenBypass_q   <= 1'b0;
      coreDomPowerOn_q <= 1'b1;
    end else begin
      unique case (cfg_q)
        pcs_pkg::CFG_ACTIVE: begin
          cpuDomClkEn_q    <= ~idleStat_q; // RULE10 RULE9
          periphClkEn_q    <= ~periphIdle_q; // RULE9
          pllRun_q         <= ~clkGen_q[pcs_pkg::CLKGEN_PLLPD_BIT]; // RULE9
          clkGenBypass_q   <= clkGen_q[pcs_pkg::CLKGEN_BYPASS_BIT];
          coreDomPowerOn_q <= 1'b1; // RULE9
        end
        pcs_pkg::CFG_LIGHT_IDLE: begin
          cpuDomClkEn_q    <= '0; // RULE5
          periphClkEn_q    <= '0; // RULE5
          pllRun_q         <= 1'b1; // RULE5
          clkGenBypass_q   <= 1'b0; // RULE5
          coreDomPowerOn_q <= 1'b1; // RULE5
        end
        pcs_pkg::CFG_DEEP_IDLE: begin
          cpuDomClkEn_q    <= '0; // RULE6
          periphClkEn_q    <= '0; // RULE6
          pllRun_q         <= 1'b0; // RULE6
          clkGenBypass_q   <= 1'b1; // RULE6
          coreDomPowerOn_q <= 1'b1; // RULE6
        end
        default: begin
          cpuDomClkEn_q    <= '0; // RULE4
          periphClkEn_q    <= '0; // RULE4
          pllRun_q         <= 1'b0; // RULE4
          clkGenBypass_q   <= 1'b1;
          coreDomPowerOn_q <= 1'b0; // RULE4
        end
      endcase
    end
  end

  // RTC clock always runs; reboot pulse on leaving RTC-only mode
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rtcReboot_q <= 1'b0;
      rtcClkEn_q  <= 1'b1;
    end else begin
      rtcReboot_q <= (cfg_q == pcs_pkg::CFG_RTC_ONLY) & rtcOnlyWake; // RULE11
      rtcClkEn_q  <= 1'b1; // RULE4 RULE5 RULE6
    end
  end

  // Sequencer events; a read clears only the bits it reported, so a late event survives
  assign evtSet[pcs_pkg::EVT_IDLE_BIT]   = enterIdle & idleCfg_q.cpu;
  assign evtSet[pcs_pkg::EVT_WAKE_BIT]   = (cfg_q == pcs_pkg::CFG_LIGHT_IDLE || cfg_q == pcs_pkg::CFG_DEEP_IDLE)
                                           & idleWake;
  assign evtSet[pcs_pkg::EVT_REBOOT_BIT] = (cfg_q == pcs_pkg::CFG_REBOOT);
  assign evtClr = (rdCommit && paddr == pcs_pkg::OFF_EVT_STAT) ? prdata_q[pcs_pkg::EVT_W-1:0] : '0;

  pcs_flag_bank #(
    .W (pcs_pkg::EVT_W)
  ) u_evtFlags (
    .ref_clk (ref_clk),
    .reset   (reset),
    .setVec  (evtSet),
    .clrVec  (evtClr),
    .flags   (evtStat)
  );

  // Level interrupt from unmasked events
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(evtStat & evtMask_q);
    end
  end

  assign pready         = pready_q;
  assign prdata         = prdata_q;
  assign pslverr        = pslverr_q;
  assign cpuDomClkEn    = cpuDomClkEn_q;
  assign periphClkEn    = periphClkEn_q;
  assign pllRun         = pllRun_q;
  assign clkGenBypass   = clkGenBypass_q;
  assign rtcClkEn       = rtcClkEn_q;
  assign coreDomPowerOn = coreDomPowerOn_q;
  assign rtcReboot      = rtcReboot_q;
  assign irq            = irq_q;

endmodule : pcs_sequencer

// ### hdl/pcs_pkg.sv
// Purpose: Shared constants and types of the power configuration sequencer
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   Offsets are byte addresses
package pcs_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_IDLE_CFG   = 8'h00;
  localparam logic [7:0] OFF_IDLE_STAT  = 8'h04;
  localparam logic [7:0] OFF_PERIPH_IDL = 8'h08;
  localparam logic [7:0] OFF_CLKGEN     = 8'h0C;
  localparam logic [7:0] OFF_RTC_PWR    = 8'h10;
  localparam logic [7:0] OFF_FLAGS_LOW  = 8'h14;
  localparam logic [7:0] OFF_FLAGS_HIGH = 8'h18;
  localparam logic [7:0] OFF_EN_LOW     = 8'h1C;
  localparam logic [7:0] OFF_EN_HIGH    = 8'h20;
  localparam logic [7:0] OFF_CONFIG     = 8'h24;
  localparam logic [7:0] OFF_EVT_STAT   = 8'h28;
  localparam logic [7:0] OFF_EVT_MASK   = 8'h2C;

  // Field positions
  localparam int CLKGEN_BYPASS_BIT  = 0;
  localparam int CLKGEN_PLLPD_BIT   = 1;
  localparam int RTC_REG_PD_BIT     = 0;
  localparam int RTC_BANDGAP_POWER_DOWN_BIT_BIT      = 1;
  localparam int RTC_WAKE_DIR_BIT   = 2;
  localparam int EVT_IDLE_BIT       = 0;
  localparam int EVT_WAKE_BIT       = 1;
  localparam int EVT_REBOOT_BIT     = 2;

  // Widths and reset values
  localparam int IDLE_W   = 6;
  localparam int PERIPH_W = 16;
  localparam int FLAG_W   = 16;
  localparam int EVT_W    = 3;
  localparam logic [IDLE_W-1:0]   IDLE_CFG_RST   = 6'h00;
  localparam logic [PERIPH_W-1:0] PERIPH_IDL_RST = 16'h0000;
  localparam logic [1:0]          CLKGEN_RST     = 2'h0;
  localparam logic [2:0]          RTC_PWR_RST    = 3'h0;

  // Per-domain idle bits of the CPU domain
  typedef struct packed {
    logic cpi;
    logic iport;
    logic dport;
    logic xport;
    logic mport;
    logic cpu;
  } pcs_idle_cfg_s;

  // Wake sources other than peripheral interrupts
  typedef struct packed {
    logic pin;
    logic rtc;
    logic extA;
    logic extB;
  } pcs_wake_s;

  // Power configuration reported to software
  typedef enum logic [2:0] {
    CFG_ACTIVE,
    CFG_LIGHT_IDLE,
    CFG_DEEP_IDLE,
    CFG_RTC_ONLY,
    CFG_REBOOT
  } pcs_cfg_e;

endpackage : pcs_pkg

// ### hdl/pcs_flag_bank.sv
// Purpose: Bank of sticky flags, set by hardware, cleared by software
// Assumes: Set and clear vectors are one-cycle qualified
// Notes:   A set in the same cycle as its clear wins
module pcs_flag_bank #(
  parameter int W = 16
) (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] setVec,
  input  wire logic [W-1:0] clrVec,
  output logic      [W-1:0] flags
);

  logic [W-1:0] flags_q;

  // Set has priority over clear
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~clrVec) | setVec;
    end
  end

  assign flags = flags_q;

endmodule : pcs_flag_bank

// ### hdl/pcs_wake_detect.sv
// Purpose: Qualifies the wake sources of the idle configurations
// Assumes: Inputs synchronous to ref_clk, levels held until served
// Notes:   Peripheral sources count only when flagged and enabled
module pcs_wake_detect (
  input  wire logic                               ref_clk,
  input  wire logic                               reset,
  input  wire pcs_pkg::pcs_wake_s                 srcs,
  input  wire logic [2*pcs_pkg::FLAG_W-1:0]       flags,
  input  wire logic [2*pcs_pkg::FLAG_W-1:0]       enables,
  output logic                                    idleWake,
  output logic                                    rtcOnlyWake
);

  logic idleWake_q;
  logic rtcOnlyWake_q;

  // Registered wake requests
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      idleWake_q    <= 1'b0;
      rtcOnlyWake_q <= 1'b0;
    end else begin
      idleWake_q    <= srcs.pin | srcs.rtc | srcs.extA | srcs.extB | (|(flags & enables)); // RULE7 RULE8
      rtcOnlyWake_q <= srcs.pin | srcs.rtc; // RULE4
    end
  end

  assign idleWake    = idleWake_q;
  assign rtcOnlyWake = rtcOnlyWake_q;

endmodule : pcs_wake_detect

// ### testbench/pcs_sequencer_checker.sv
// Purpose: Port-level assertions of the power configuration sequencer
// Assumes: Single clock domain, synchronous active-high reset
// Notes:   Bound onto every pcs_sequencer instance
module pcs_sequencer_checker (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        rtcIrq,
  input wire logic        externalIrqA,
  input wire logic        externalIrqB,
  input wire logic [5:0]  cpuDomClkEn,
  input wire logic [15:0] periphClkEn,
  input wire logic        pllRun,
  input wire logic        clkGenBypass,
  input wire logic        rtcClkEn,
  input wire logic        coreDomPowerOn,
  input wire logic        rtcReboot,
  input wire logic        irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // Bus and wake step sequences
  sequence sAccessStart;
    psel && $rose(penable);
  endsequence
  sequence sIdleWake;
    coreDomPowerOn && !cpuDomClkEn[0] && (rtcIrq || externalIrqA || externalIrqB);
  endsequence
  sequence sRtcOnlyWake;
    !coreDomPowerOn && $rose(rtcIrq);
  endsequence

  AST_ONE_WAIT:     assert property (sAccessStart |-> !pready ##1 pready) else $error("pready wait wrong");
  AST_READY_QUAL:   assert property (pready |-> psel && penable) else $error("pready outside access");
  AST_ERR_QUAL:     assert property (pslverr |-> pready) else $error("pslverr without pready");
  AST_RDATA_IDLE:   assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
  AST_RTC_CLK:      assert property (rtcClkEn) else $error("rtc clock stopped");
  AST_RESET_VALUES: assert property ($fell(reset) |-> cpuDomClkEn == 6'h3F && periphClkEn == 16'hFFFF
                      && pllRun && !clkGenBypass && coreDomPowerOn && !irq) else $error("bad reset state");
  AST_IDLE_WAKE:    assert property (sIdleWake |-> ##[1:4] cpuDomClkEn[0]) else $error("no idle wake");
  AST_RTC_WAKE:     assert property (sRtcOnlyWake |-> ##[1:4] rtcReboot) else $error("no reboot");
  AST_REBOOT_PULSE: assert property (rtcReboot |=> !rtcReboot) else $error("reboot not a pulse");
  AST_LIGHT_PLL:    assert property (!cpuDomClkEn[0] && !clkGenBypass |-> pllRun) else $error("pll stopped");
endmodule : pcs_sequencer_checker

bind pcs_sequencer pcs_sequencer_checker u_chk (
  .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .rtcIrq(rtcIrq), .externalIrqA(externalIrqA), .externalIrqB(externalIrqB),
  .cpuDomClkEn(cpuDomClkEn), .periphClkEn(periphClkEn), .pllRun(pllRun), .clkGenBypass(clkGenBypass),
  .rtcClkEn(rtcClkEn), .coreDomPowerOn(coreDomPowerOn), .rtcReboot(rtcReboot), .irq(irq)
);

// ### testbench/tb_pcs_sequencer.sv
// Purpose: Self-checking bench of the power configuration sequencer
// Assumes: APB master drives on rising edges, 200 MHz clock
// Notes:   Wake sources are held six cycles, then dropped
module tb_pcs_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic               ref_clk = 1'b0;
  logic               reset = 1'b1;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic [31:0]        rd;
  logic               pready, pslverr, err;
  logic               idleInstr = 1'b0;
  pcs_pkg::pcs_wake_s src = '0;
  logic [31:0]        periphIrq = 32'h0;
  logic [5:0]         cpuDomClkEn;
  logic [15:0]        periphClkEn;
  logic               pllRun, clkGenBypass, rtcClkEn, coreDomPowerOn, rtcReboot, irq;
  int                 fails = 0;
  int                 nTests = 0;
  int                 cycles = 0;
  int                 reboots = 0;

  pcs_sequencer uut (
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .idleInstr(idleInstr),
    .wakeRequestPin(src.pin), .rtcIrq(src.rtc), .externalIrqA(src.extA), .externalIrqB(src.extB),
    .periphIrq(periphIrq), .cpuDomClkEn(cpuDomClkEn), .periphClkEn(periphClkEn), .pllRun(pllRun),
    .clkGenBypass(clkGenBypass), .rtcClkEn(rtcClkEn), .coreDomPowerOn(coreDomPowerOn),
    .rtcReboot(rtcReboot), .irq(irq)
  );

  // Clock
  always #2.5 ref_clk = ~ref_clk;

  // Timeout and reboot pulse count
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (rtcReboot === 1'b1) reboots <= reboots + 1;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end

  task automatic final_report();
    if (fails == 0 && nTests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(what, q, exp);
  endtask : rdc

  task automatic goIdle();
    @(posedge ref_clk);
    idleInstr <= 1'b1;
    @(posedge ref_clk);
    idleInstr <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask : goIdle

  task automatic wake(input pcs_pkg::pcs_wake_s s, input logic [31:0] p);
    @(posedge ref_clk);
    src <= s;
    periphIrq <= p;
    @(posedge ref_clk);
    periphIrq <= 32'h0;
    repeat (5) @(posedge ref_clk);
    src <= '0;
    repeat (2) @(posedge ref_clk);
  endtask : wake

  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    chk("cpuDomClkEn", 32'(cpuDomClkEn), 32'h3F);
    chk("periphClkEn", 32'(periphClkEn), 32'hFFFF);
    rdc("idleCfg", pcs_pkg::OFF_IDLE_CFG, 32'h0);
    rdc("clkGen", pcs_pkg::OFF_CLKGEN, 32'h0);
    wr(pcs_pkg::OFF_CONFIG, 32'h3);
    rdc("config", pcs_pkg::OFF_CONFIG, 32'(pcs_pkg::CFG_ACTIVE));
    apb(1'b0, 8'h30, 32'h0, rd, err);
    chk("pslverr", 32'(err), 32'h1);
    // Peripheral idle bits gate the peripheral clocks
    wr(pcs_pkg::OFF_PERIPH_IDL, 32'h00FF);
    rdc("periphIdl", pcs_pkg::OFF_PERIPH_IDL, 32'h00FF);
    chk("periphClkEn", 32'(periphClkEn), 32'hFF00);
    wr(pcs_pkg::OFF_PERIPH_IDL, 32'h0);
    wr(pcs_pkg::OFF_EVT_MASK, 32'h7);
    wr(pcs_pkg::OFF_RTC_PWR, 32'h4);
    wr(pcs_pkg::OFF_FLAGS_LOW, 32'hFFFF);
    wr(pcs_pkg::OFF_FLAGS_HIGH, 32'hFFFF);
    wr(pcs_pkg::OFF_IDLE_CFG, 32'h3F);
    // Light and deep idle, two wake sources each
    for (int i = 0; i < 4; i++) begin
      wr(pcs_pkg::OFF_CLKGEN, i[0] ? 32'h3 : 32'h0);
      goIdle();
      rdc("config", pcs_pkg::OFF_CONFIG, i[0] ? 32'h2 : 32'h1);
      rdc("idleStat", pcs_pkg::OFF_IDLE_STAT, 32'h3F);
      chk("cpuDomClkEn", 32'(cpuDomClkEn), 32'h0);
      chk("periphClkEn", 32'(periphClkEn), 32'h0);
      chk("pllRun", 32'(pllRun), 32'(!i[0]));
      chk("clkGenBypass", 32'(clkGenBypass), 32'(i[0]));
      wake(pcs_pkg::pcs_wake_s'(4'(1 << i)), 32'h0);
      chk("cpuRun", 32'(cpuDomClkEn[0]), 32'h1);
      chk("irq", 32'(irq), 32'h1);
      rdc("evtStat", pcs_pkg::OFF_EVT_STAT, 32'h3);
      rdc("evtStat", pcs_pkg::OFF_EVT_STAT, 32'h0);
      chk("irq", 32'(irq), 32'h0);
    end
    // Peripheral wake needs flag and enable
    wr(pcs_pkg::OFF_CLKGEN, 32'h0);
    wr(pcs_pkg::OFF_EN_LOW, 32'h8);
    goIdle();
    wake('0, 32'h0001_0020);
    chk("cpuDomClkEn", 32'(cpuDomClkEn), 32'h0);
    wake('0, 32'h0000_0008);
    chk("cpuRun", 32'(cpuDomClkEn[0]), 32'h1);
    rdc("flagsLow", pcs_pkg::OFF_FLAGS_LOW, 32'h28);
    rdc("flagsHigh", pcs_pkg::OFF_FLAGS_HIGH, 32'h1);
    wr(pcs_pkg::OFF_FLAGS_LOW, 32'h28);
    rdc("flagsLow", pcs_pkg::OFF_FLAGS_LOW, 32'h0);
    rdc("evtStat", pcs_pkg::OFF_EVT_STAT, 32'h3);
    // RTC-only entry and reboot on wake
    wr(pcs_pkg::OFF_RTC_PWR, 32'h3);
    repeat (3) @(posedge ref_clk);
    rdc("config", pcs_pkg::OFF_CONFIG, 32'(pcs_pkg::CFG_RTC_ONLY));
    chk("coreDomPowerOn", 32'(coreDomPowerOn), 32'h0);
    wake(4'h4, 32'h0);
    chk("reboots", 32'(reboots), 32'h1);
    chk("coreDomPowerOn", 32'(coreDomPowerOn), 32'h1);
    rdc("config", pcs_pkg::OFF_CONFIG, 32'(pcs_pkg::CFG_ACTIVE));
    rdc("rtcPwr", pcs_pkg::OFF_RTC_PWR, 32'h0);
    rdc("evtStat", pcs_pkg::OFF_EVT_STAT, 32'h4);
    final_report();
  end
endmodule : tb_pcs_sequencer
